// ---- core/hcr_top.sv ----
/*
 * Power-management and SMI logic of a host-bus-to-card-socket bridge:
 * SMI generation and routing, host clock-run, serial IRQ2 slot,
 * card clock stopping on the link clock, 16-bit float and suspend.
 * Assumes a single-cycle register port on CLK and pins from outside.
 */
// Notes on behaviour
// - Serial IRQ packet: start, 21 indication slots, stop; 16 IRQs plus 5 other lines.
// - With SMI enabled, a power-launching write raises SMI.
// - System control: path select bit 26, pending bit 25, enable bit 24.
// - Path select sends SMI as status change or as IRQ2.
// - Per-socket pending flag set on SMI, cleared by writing one.
// - Status-change path signals SMI per socket, level or edge style.
// - IRQ2 path carries SMI in the IRQ2 slot of the serial packet.
// - Parallel IRQ2 low only when pin 3 or pin 6 routes IRQ2.
// - Clock-run uses multifunction pin 6, which must be routed to it.
// - Refuse host clock stop while hold-clock bit 1 is set.
// - Refuse stop while 16-bit, master machine busy or posted data remain.
// - Refuse stop while interrupts pend or a card clock still runs.
// - Restart host clock on card interrupt, wake, clock-run or bus request.
// - Stop a socket's card clock when idle, via the card clock-run line.
// - Output-float bit 7 floats the 16-bit interface and resets the card.
// - Auto-float bit 0 floats the idle interface without card reset.
// - Suspend blocks bus and global resets and gates the internal clock.
// - Suspend floats bus outputs; gating waits while grant is asserted.
// - Resets during suspend keep register contents.
// - Asynchronous status changes pass unclocked; serial ones wait for the clock.
// - Pins stay active during suspend.
`timescale 1ns/1ps
`default_nettype none
`include "hcr_defines.svh"
module hcr_top #(
  parameter int NUM_SOCKETS = 2,
  parameter int IDLE_CYCLES = 16
) (
  input  wire logic                   CLK,
  input  wire logic                   RESET,
  input  wire logic                   GLOBAL_RESET_INPUT,
  input  wire logic                   SUSPEND,
  input  wire logic                   BUS_GRANT,
  input  wire logic [11:0]            REG_ADDR,
  input  wire logic [31:0]            REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_SOCKET,
  output logic      [31:0]            REG_RDATA,
  input  wire logic                   LEGACY_BUSY,
  input  wire logic                   MASTER_BUSY,
  input  wire logic                   POSTED_DATA,
  input  wire logic [NUM_SOCKETS-1:0] CARD_IRQ,
  input  wire logic [NUM_SOCKETS-1:0] CARD_WAKE,
  input  wire logic [NUM_SOCKETS-1:0] CARD_REQ,
  input  wire logic [NUM_SOCKETS-1:0] CARD_ACTIVE,
  input  wire logic                   CLKRUN_IN,
  output logic                        CLKRUN_OUT,
  output logic                        CLKRUN_OE,
  input  wire logic                   SERIAL_IRQ_IN,
  output logic                        SERIAL_IRQ_OUT,
  output logic                        SERIAL_IRQ_OE,
  output logic                        MULTI_USE_PIN_3_N,
  output logic                        MULTI_USE_PIN_6_N,
  output logic [NUM_SOCKETS-1:0]      STATUS_CHANGE_IRQ,
  output logic [NUM_SOCKETS-1:0]      CARD_FLOAT,
  output logic [NUM_SOCKETS-1:0]      CARD_RESET,
  output logic                        BUS_OUTPUTS_OE,
  output logic                        CLOCK_GATED,
  input  wire logic                   LINK_CLK,
  input  wire logic [NUM_SOCKETS-1:0] CCLKRUN_IN,
  output logic [NUM_SOCKETS-1:0]      CCLKRUN_OUT,
  output logic [NUM_SOCKETS-1:0]      CCLKRUN_OE,
  output logic [NUM_SOCKETS-1:0]      CARD_CLK_RUN
);
  // Socket select is one bit wide and the idle counter eight bits
  if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2 || IDLE_CYCLES < 2 || IDLE_CYCLES > 255)
  begin : g_param_check
    $error("hcr_top: unsupported parameters");
  end

  localparam int SN = NUM_SOCKETS;

  // Pin synchronisers; the first stage is read only by the second
  logic [1:0] susp_s, global_reset_input_s, gnt_s, ckr_s, sirq_s;
  logic [SN-1:0] irq_a, irq_b, wake_a, wake_b, req_a, req_b, stop_a, stop_b;
  always_ff @(posedge CLK)
  begin
    susp_s <= {susp_s[0], SUSPEND};
    global_reset_input_s <= {global_reset_input_s[0], GLOBAL_RESET_INPUT};
    gnt_s  <= {gnt_s[0], BUS_GRANT};
    ckr_s  <= {ckr_s[0], CLKRUN_IN};
    sirq_s <= {sirq_s[0], SERIAL_IRQ_IN};
    irq_a  <= CARD_IRQ;
    irq_b  <= irq_a;
    wake_a <= CARD_WAKE;
    wake_b <= wake_a;
    req_a  <= CARD_REQ;
    req_b  <= req_a;
  end
  wire logic suspended = susp_s[1];

  // Resets are blocked while suspended, so register contents survive
  wire logic rst = (RESET | global_reset_input_s[1]) & ~suspended;

  // Internal clock gating holds off while a granted transaction runs
  logic gated_reg;
  always_ff @(posedge CLK)
  begin
    if (rst)
      gated_reg <= 1'b0;
    else if (!suspended)
      gated_reg <= 1'b0;
    else if (!gnt_s[1])
      gated_reg <= 1'b1;
  end
  wire logic run = ~gated_reg;

  // Registers
  logic [31:0] sysctl_reg, route_reg;
  logic [7:0]  cpow_reg [SN];
  logic [7:0]  gctl_reg [SN];
  logic [31:0] spow_reg [SN];
  logic [SN-1:0] pend_reg, launch;
  wire logic gen_on = sysctl_reg[`HCR_BIT_GEN_ON];
  wire logic path_irq2 = sysctl_reg[`HCR_BIT_PATH_SELECT];

  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      sysctl_reg <= `HCR_RST_SYSTEM_CTRL;
      route_reg  <= `HCR_RST_MULTIPIN;
    end
    else if (REG_WR && run)
    begin
      if (REG_ADDR == `HCR_OFF_SYSTEM_CTRL)
      begin
        sysctl_reg <= REG_WDATA;
        sysctl_reg[`HCR_BIT_PENDING] <= 1'b0;
      end
      if (REG_ADDR == `HCR_OFF_MULTIPIN)
        route_reg <= REG_WDATA;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SN; g++)
    begin : g_sock
      wire logic sel = (REG_SOCKET == 1'(g)) && REG_WR && run;
      assign launch[g] = sel && (REG_ADDR == `HCR_OFF_CARD_POWER ||
                                 REG_ADDR == `HCR_OFF_SOCKET_POWER);
      always_ff @(posedge CLK)
      begin
        if (rst)
        begin
          cpow_reg[g] <= `HCR_RST_BYTE;
          gctl_reg[g] <= `HCR_RST_BYTE;
          spow_reg[g] <= `HCR_RST_SYSTEM_CTRL;
        end
        else if (sel)
        begin
          if (REG_ADDR == `HCR_OFF_CARD_POWER)
            cpow_reg[g] <= REG_WDATA[7:0];
          if (REG_ADDR == `HCR_OFF_GLOBAL_CTRL)
            gctl_reg[g] <= REG_WDATA[7:0];
          if (REG_ADDR == `HCR_OFF_SOCKET_POWER)
            spow_reg[g] <= REG_WDATA;
        end
      end
      // Set wins over a write-one clear in the same cycle
      always_ff @(posedge CLK)
      begin
        if (rst)
          pend_reg[g] <= 1'b0;
        else if (gen_on && launch[g])
          pend_reg[g] <= 1'b1;
        else if (sel && REG_ADDR == `HCR_OFF_SYSTEM_CTRL && REG_WDATA[`HCR_BIT_PENDING])
          pend_reg[g] <= 1'b0;
      end
      // Edge style gives a one-cycle pulse, level style holds until cleared
      logic pend_d;
      always_ff @(posedge CLK)
      begin
        if (rst)
        begin
          pend_d <= 1'b0;
          STATUS_CHANGE_IRQ[g] <= 1'b0;
        end
        else
        begin
          pend_d <= pend_reg[g];
          STATUS_CHANGE_IRQ[g] <= ~path_irq2 & pend_reg[g] &
            (~gctl_reg[g][`HCR_BIT_TRIGGER_STYLE] | ~pend_d);
        end
      end
      // Float and card reset; auto-float only floats an idle card
      always_ff @(posedge CLK)
      begin
        if (rst)
        begin
          CARD_FLOAT[g] <= 1'b0;
          CARD_RESET[g] <= 1'b0;
        end
        else
        begin
          CARD_FLOAT[g] <= cpow_reg[g][`HCR_BIT_OUTPUT_FLOAT] |
            (gctl_reg[g][`HCR_BIT_AUTO_FLOAT] & ~req_b[g] & ~irq_b[g] & stop_b[g]);
          CARD_RESET[g] <= cpow_reg[g][`HCR_BIT_OUTPUT_FLOAT];
        end
      end

      // Link domain: card clock manager on the card link clock
      logic [1:0] lrst_s, act_s, ckr_l;
      logic [7:0] idle_reg;
      logic       stopped_reg;
      always_ff @(posedge LINK_CLK)
      begin
        lrst_s <= {lrst_s[0], rst};
        act_s  <= {act_s[0], CARD_ACTIVE[g]};
        ckr_l  <= {ckr_l[0], CCLKRUN_IN[g]};
      end
      always_ff @(posedge LINK_CLK)
      begin
        if (lrst_s[1] || act_s[1])
          idle_reg <= 8'h00;
        else if (idle_reg != 8'(IDLE_CYCLES))
          idle_reg <= idle_reg + 8'h01;
      end
      // Stop is requested by releasing the line; a card pulling it low restarts
      always_ff @(posedge LINK_CLK)
      begin
        if (lrst_s[1])
        begin
          stopped_reg       <= 1'b0;
          CCLKRUN_OUT[g]    <= 1'b0;
          CCLKRUN_OE[g]     <= 1'b1;
          CARD_CLK_RUN[g]   <= 1'b1;
        end
        else if (!stopped_reg && idle_reg == 8'(IDLE_CYCLES))
        begin
          CCLKRUN_OE[g]     <= 1'b0;
          if (ckr_l[1])
          begin
            stopped_reg     <= 1'b1;
            CARD_CLK_RUN[g] <= 1'b0;
          end
        end
        else if (stopped_reg && (!ckr_l[1] || act_s[1]))
        begin
          stopped_reg       <= 1'b0;
          CARD_CLK_RUN[g]   <= 1'b1;
          CCLKRUN_OE[g]     <= 1'b1;
        end
        else if (!stopped_reg)
          CCLKRUN_OE[g]     <= 1'b1;
      end
      // Stopped level crosses back by two flip-flops
      always_ff @(posedge CLK)
      begin
        stop_a[g] <= stopped_reg;
        stop_b[g] <= stop_a[g];
      end
    end
  endgenerate

  // Register read-back
  always_ff @(posedge CLK)
  begin
    if (rst)
      REG_RDATA <= 32'h0000_0000;
    else
    begin
      case (REG_ADDR)
        `HCR_OFF_SYSTEM_CTRL:
        begin
          REG_RDATA <= sysctl_reg;
          REG_RDATA[`HCR_BIT_PENDING] <= pend_reg[REG_SOCKET % SN];
        end
        `HCR_OFF_MULTIPIN:    REG_RDATA <= route_reg;
        `HCR_OFF_CARD_POWER:  REG_RDATA <= {24'h00_0000, cpow_reg[REG_SOCKET % SN]};
        `HCR_OFF_GLOBAL_CTRL: REG_RDATA <= {24'h00_0000, gctl_reg[REG_SOCKET % SN]};
        `HCR_OFF_SOCKET_POWER: REG_RDATA <= spow_reg[REG_SOCKET % SN];
        default:              REG_RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Host clock-run on pin 6
  wire logic clkrun_on = route_reg[`HCR_PIN6_LSB +: 4] == `HCR_ROUTE_CLOCK_RUN;
  wire logic irq_pend = |pend_reg | |irq_b;
  wire logic refuse = sysctl_reg[`HCR_BIT_HOLD_CLOCK]
                    | LEGACY_BUSY | MASTER_BUSY | POSTED_DATA
                    | irq_pend | ~&stop_b;
  wire logic wake = |irq_b | |wake_b | |req_b | ~&stop_b;
  logic [1:0] drive_reg;
  always_ff @(posedge CLK)
  begin
    if (rst)
      drive_reg <= 2'h0;
    else if (drive_reg != 2'h0)
      drive_reg <= drive_reg - 2'h1;
    else if (clkrun_on && ckr_s[1] && (refuse || wake))
      drive_reg <= 2'(`HCR_REFUSE_CLOCKS);
  end
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      CLKRUN_OUT <= 1'b0;
      CLKRUN_OE  <= 1'b0;
    end
    else
    begin
      CLKRUN_OUT <= 1'b0;
      CLKRUN_OE  <= drive_reg != 2'h0;
    end
  end

  // Serial IRQ: host starts the frame, each slot is three clocks
  hcr_pkg::hcr_sirq_t sirq_reg;
  logic [4:0] slot_reg;
  logic [1:0] phase_reg;
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      sirq_reg  <= hcr_pkg::SIRQ_IDLE;
      slot_reg  <= 5'h00;
      phase_reg <= 2'h0;
    end
    else if (run)
    begin
      case (sirq_reg)
        hcr_pkg::SIRQ_IDLE:
          if (!sirq_s[1])
            sirq_reg <= hcr_pkg::SIRQ_START;
        hcr_pkg::SIRQ_START:
          if (sirq_s[1])
          begin
            sirq_reg  <= hcr_pkg::SIRQ_SLOTS;
            slot_reg  <= 5'h00;
            phase_reg <= 2'h0;
          end
        hcr_pkg::SIRQ_SLOTS:
          if (phase_reg == 2'(`HCR_SLOT_CLOCKS - 1))
          begin
            phase_reg <= 2'h0;
            if (slot_reg == `HCR_LAST_SLOT)
              sirq_reg <= hcr_pkg::SIRQ_IDLE;
            else
              slot_reg <= slot_reg + 5'h01;
          end
          else
            phase_reg <= phase_reg + 2'h1;
        default: sirq_reg <= hcr_pkg::SIRQ_IDLE;
      endcase
    end
  end
  wire logic smi_irq2 = path_irq2 & |pend_reg;
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      SERIAL_IRQ_OUT <= 1'b0;
      SERIAL_IRQ_OE  <= 1'b0;
    end
    else
    begin
      SERIAL_IRQ_OUT <= 1'b0;
      SERIAL_IRQ_OE  <= run && smi_irq2 && sirq_reg == hcr_pkg::SIRQ_SLOTS &&
                        slot_reg == `HCR_IRQ2_SLOT && phase_reg == 2'h0;
    end
  end

  // Parallel IRQ2, pins stay live in suspend; bus outputs float
  always_ff @(posedge CLK)
  begin
    if (rst)
    begin
      MULTI_USE_PIN_3_N <= 1'b1;
      MULTI_USE_PIN_6_N <= 1'b1;
      BUS_OUTPUTS_OE    <= 1'b0;
      CLOCK_GATED       <= 1'b0;
    end
    else
    begin
      MULTI_USE_PIN_3_N <= ~(smi_irq2 &&
        route_reg[`HCR_PIN3_LSB +: 4] == `HCR_ROUTE_IRQ2);
      MULTI_USE_PIN_6_N <= ~(smi_irq2 &&
        route_reg[`HCR_PIN6_LSB +: 4] == `HCR_ROUTE_IRQ2);
      BUS_OUTPUTS_OE    <= ~suspended | gnt_s[1];
      CLOCK_GATED       <= gated_reg;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (rst);

  sequence s_launch; gen_on && launch[0]; endsequence
  property p_smi_set;
    s_launch |=> pend_reg[0];
  endproperty
  a_smi_set: assert property (p_smi_set) else $error("pending not set");
  property p_pend_hold;
    $fell(pend_reg[0]) && !$past(rst) |-> $past(REG_WR) && $past(REG_WDATA[25]);
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending cleared");
  property p_hold_refuse;
    clkrun_on && ckr_s[1] && sysctl_reg[1] && drive_reg == 2'h0 |=> ##1 CLKRUN_OE;
  endproperty
  a_hold_refuse: assert property (p_hold_refuse) else $error("stop not refused");
  property p_busy_refuse;
    clkrun_on && ckr_s[1] && MASTER_BUSY && drive_reg == 2'h0 |=> drive_reg == 2'h2;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy not refused");
  property p_noroute;
    !clkrun_on && drive_reg == 2'h0 |=> ##1 !CLKRUN_OE;
  endproperty
  a_noroute: assert property (p_noroute) else $error("clock-run unrouted");
  property p_float;
    cpow_reg[0][7] |=> CARD_FLOAT[0] && CARD_RESET[0];
  endproperty
  a_float: assert property (p_float) else $error("float missing");
  property p_bus_float;
    suspended && !gnt_s[1] |=> !BUS_OUTPUTS_OE;
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus not floated");
  property p_irq2_pin;
    smi_irq2 && route_reg[27:24] == 4'h2 |=> !MULTI_USE_PIN_6_N;
  endproperty
  a_irq2_pin: assert property (p_irq2_pin) else $error("irq2 pin idle");
  property p_csc;
    !path_irq2 && !gctl_reg[0][1] && pend_reg[0] |=> STATUS_CHANGE_IRQ[0];
  endproperty
  a_csc: assert property (p_csc) else $error("status change missing");
endmodule
`default_nettype wire

// ---- core/hcr_defines.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the
 * host clock-run, suspend and SMI block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef HCR_DEFINES_SVH
`define HCR_DEFINES_SVH

`define HCR_OFF_CARD_POWER    12'h002
`define HCR_OFF_SOCKET_POWER  12'h010
`define HCR_OFF_GLOBAL_CTRL   12'h01e
`define HCR_OFF_SYSTEM_CTRL   12'h080
`define HCR_OFF_MULTIPIN      12'h08c

`define HCR_BIT_PATH_SELECT   26
`define HCR_BIT_PENDING       25
`define HCR_BIT_GEN_ON        24
`define HCR_BIT_HOLD_CLOCK    1
`define HCR_BIT_OUTPUT_FLOAT  7
`define HCR_BIT_AUTO_FLOAT    0
`define HCR_BIT_TRIGGER_STYLE 1

`define HCR_PIN3_LSB          12
`define HCR_PIN6_LSB          24
`define HCR_ROUTE_IRQ2        4'h2
`define HCR_ROUTE_CLOCK_RUN   4'hc

`define HCR_RST_SYSTEM_CTRL   32'h0000_0000
`define HCR_RST_MULTIPIN      32'h0000_0000
`define HCR_RST_BYTE          8'h00

`define HCR_SLOT_CLOCKS       3
`define HCR_IRQ2_SLOT         5'h02
`define HCR_LAST_SLOT         5'h14
`define HCR_REFUSE_CLOCKS     2

`endif

// ---- core/hcr_pkg.sv ----
/*
 * Types of the host clock-run, suspend and SMI block.
 * Assumes the defines header sits beside it.
 */
`include "hcr_defines.svh"
package hcr_pkg;
  typedef enum logic [1:0] {SIRQ_IDLE, SIRQ_START, SIRQ_SLOTS} hcr_sirq_t;
endpackage

// ---- bench/hcr_host_model.sv ----
/*
 * Host chipset model: central clock resource, serial IRQ host, arbiter.
 * Assumes pull-ups on the clock-run and serial IRQ lines.
 */
`timescale 1ns/1ps
`default_nettype none
module hcr_host_model (
  input  wire logic clk,
  input  wire logic stop_req,
  input  wire logic tx_busy,
  input  wire logic clkrun_oe,
  input  wire logic serial_irq_oe,
  output logic      clkrun_in,
  output logic      serial_irq_in,
  output logic      bus_grant
);
  logic start_low = 1'b0;
  // Host holds clock-run low while the clock must run; released means stop
  assign clkrun_in = !(clkrun_oe || !stop_req);
  assign serial_irq_in = !(serial_irq_oe || start_low);
  // Grant only during a transfer, never parked on the device
  assign bus_grant = tx_busy;
  task automatic frame(output int lows);
    lows = 0;
    start_low = 1'b1;
    repeat (4) @(posedge clk);
    #1 start_low = 1'b0;
    // 21 slots of 3 clocks after the start cycle
    // Sample after the edge so the slot drive launched there has settled
    repeat (63)
    begin
      @(posedge clk);
      #1;
      if (serial_irq_in === 1'b0) lows++;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/hcr_top_bench.sv ----
/*
 * Self-checking bench of the clock-run, suspend and SMI block.
 * Assumes the host model beside it and the design's defines header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hcr_defines.svh"
module hcr_top_bench;
  logic        clk, link_clk, reset, global_rst, suspend, tx_busy, stop_req;
  logic        reg_wr, reg_socket, legacy_busy, master_busy, posted_data;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0]  wk;
  logic [1:0]  cclk_oe, sc_irq, c_float, c_reset, c_run, cclkrun_in, cclk_out;
  logic        cr_in, cr_oe, si_in, si_oe, grant, bus_oe, gated, pin3_n, pin6_n;
  logic        cr_out, si_out, act;
  int          fails, checked, n, i;
  assign cclkrun_in = ~(cclk_oe | {1'b0, wk[3]});
  hcr_top #(.IDLE_CYCLES(4)) u_hcr_top (
    .CLK(clk), .RESET(reset), .GLOBAL_RESET_INPUT(global_rst), .SUSPEND(suspend),
    .BUS_GRANT(grant), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_SOCKET(reg_socket), .REG_RDATA(reg_rdata), .LEGACY_BUSY(legacy_busy),
    .MASTER_BUSY(master_busy), .POSTED_DATA(posted_data), .CARD_IRQ({1'b0, wk[0]}),
    .CARD_WAKE({1'b0, wk[1]}), .CARD_REQ({wk[2], 1'b0}), .CARD_ACTIVE({1'b0, act}),
    .CLKRUN_IN(cr_in), .CLKRUN_OUT(cr_out), .CLKRUN_OE(cr_oe), .SERIAL_IRQ_IN(si_in),
    .SERIAL_IRQ_OUT(si_out), .SERIAL_IRQ_OE(si_oe), .MULTI_USE_PIN_3_N(pin3_n),
    .MULTI_USE_PIN_6_N(pin6_n), .STATUS_CHANGE_IRQ(sc_irq), .CARD_FLOAT(c_float),
    .CARD_RESET(c_reset), .BUS_OUTPUTS_OE(bus_oe), .CLOCK_GATED(gated),
    .LINK_CLK(link_clk), .CCLKRUN_IN(cclkrun_in), .CCLKRUN_OUT(cclk_out), .CCLKRUN_OE(cclk_oe),
    .CARD_CLK_RUN(c_run));
  hcr_host_model u_hcr_host_model (
    .clk(clk), .stop_req(stop_req), .tx_busy(tx_busy), .clkrun_oe(cr_oe),
    .serial_irq_oe(si_oe), .clkrun_in(cr_in), .serial_irq_in(si_in), .bus_grant(grant));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Link clock offset so its edges never line up with the host clock
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic s);
    reg_addr = a;
    reg_wdata = v;
    reg_socket = s;
    reg_wr = 1'b1;
    tk(1);
    reg_wr = 1'b0;
    tk(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic s);
    reg_addr = a;
    reg_socket = s;
    tk(2);
    d = reg_rdata;
  endtask
  task automatic ask(input logic e, input string nm);
    logic seen;
    seen = 1'b0;
    stop_req = 1'b1;
    repeat (12)
    begin
      tk(1);
      seen |= cr_oe;
    end
    stop_req = 1'b0;
    tk(4);
    chk(nm, seen, e);
  endtask
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cstop;
    for (int k = 0; k < 300 && c_run !== 2'b00; k++)
      tk(1);
    chk("card clk stopped", c_run, 2'b00);
    if (c_run !== 2'b00)
      conclude;
  endtask
  task automatic t_smi;
    wr(`HCR_OFF_SOCKET_POWER, 32'h0, 1'b0);
    rd(`HCR_OFF_SYSTEM_CTRL, 1'b0);
    chk("pend off", d[25], 1'b0);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0100_0000, 1'b0);
    wr(`HCR_OFF_SOCKET_POWER, 32'h0, 1'b0);
    rd(`HCR_OFF_SYSTEM_CTRL, 1'b0);
    chk("pend s0", d[25], 1'b1);
    chk("csc s0", sc_irq, 2'b01);
    wr(`HCR_OFF_CARD_POWER, 32'h0, 1'b1);
    chk("csc both", sc_irq, 2'b11);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0300_0000, 1'b0);
    tk(1);
    chk("clear s0", sc_irq, 2'b10);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0300_0000, 1'b1);
    wr(`HCR_OFF_GLOBAL_CTRL, 32'h2, 1'b0);
    wr(`HCR_OFF_SOCKET_POWER, 32'h0, 1'b0);
    n = 0;
    repeat (6)
    begin
      n += sc_irq[0];
      tk(1);
    end
    chk("edge pulse", n, 1);
    wr(`HCR_OFF_GLOBAL_CTRL, 32'h0, 1'b0);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0300_0000, 1'b0);
    $display("test smi done");
  endtask
  task automatic t_irq2;
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0500_0000, 1'b0);
    wr(`HCR_OFF_SOCKET_POWER, 32'h0, 1'b0);
    tk(1);
    chk("no csc", sc_irq, 2'b00);
    chk("pin3 unrouted", pin3_n, 1'b1);
    u_hcr_host_model.frame(n);
    chk("irq2 slot", n, 1);
    wr(`HCR_OFF_MULTIPIN, 32'h0000_2000, 1'b0);
    chk("pin3", {pin6_n, pin3_n}, 2'b10);
    wr(`HCR_OFF_MULTIPIN, 32'h0200_0000, 1'b0);
    chk("pin6", {pin6_n, pin3_n}, 2'b01);
    wr(`HCR_OFF_MULTIPIN, 32'h0000_0200, 1'b0);
    chk("pin2", {pin6_n, pin3_n}, 2'b11);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0200_0000, 1'b0);
    u_hcr_host_model.frame(n);
    chk("slot idle", n, 0);
    wr(`HCR_OFF_MULTIPIN, 32'h0, 1'b0);
    $display("test irq2 done");
  endtask
  task automatic t_float;
    wr(`HCR_OFF_CARD_POWER, 32'h80, 1'b0);
    chk("float", {c_float, c_reset}, 4'h5);
    wr(`HCR_OFF_CARD_POWER, 32'h0, 1'b0);
    wr(`HCR_OFF_GLOBAL_CTRL, 32'h1, 1'b1);
    tk(2);
    chk("auto float", {c_float, c_reset}, 4'h8);
    wr(`HCR_OFF_GLOBAL_CTRL, 32'h0, 1'b1);
    $display("test float done");
  endtask
  task automatic t_clk;
    cstop;
    act = 1'b1;
    tk(2);
    chk("active runs", c_run[0], 1'b1);
    act = 1'b0;
    cstop;
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h2, 1'b0);
    ask(1'b0, "unrouted");
    wr(`HCR_OFF_MULTIPIN, 32'h0c00_0000, 1'b0);
    ask(1'b1, "hold");
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0, 1'b0);
    ask(1'b0, "idle");
    for (i = 0; i < 3; i++)
    begin
      {legacy_busy, master_busy, posted_data} = 3'h1 << i;
      ask(1'b1, "busy");
      {legacy_busy, master_busy, posted_data} = 3'h0;
    end
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0100_0000, 1'b0);
    wr(`HCR_OFF_SOCKET_POWER, 32'h0, 1'b0);
    ask(1'b1, "irq pend");
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0200_0000, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      stop_req = 1'b1;
      tk(8);
      chk("stop taken", cr_oe, 1'b0);
      wk = 4'h1 << i;
      n = 0;
      repeat (12)
      begin
        tk(1);
        n += cr_oe;
      end
      chk("restart", n > 0, 1'b1);
      if (i == 3)
        chk("card clk on", c_run[0], 1'b1);
      wk = 4'h0;
      stop_req = 1'b0;
      tk(4);
      cstop;
    end
    chk("pins drive low", {cr_out, si_out, cclk_out}, 4'h0);
    $display("test clock run done");
  endtask
  task automatic t_susp;
    wr(`HCR_OFF_MULTIPIN, 32'h0c00_2000, 1'b0);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0500_0002, 1'b0);
    wr(`HCR_OFF_SOCKET_POWER, 32'h0, 1'b0);
    chk("irq2 pin", pin3_n, 1'b0);
    tx_busy = 1'b1;
    suspend = 1'b1;
    tk(6);
    chk("gate waits", gated, 1'b0);
    tx_busy = 1'b0;
    tk(6);
    chk("gated", gated, 1'b1);
    chk("bus float", bus_oe, 1'b0);
    wr(`HCR_OFF_SYSTEM_CTRL, 32'h0, 1'b0);
    reset = 1'b1;
    global_rst = 1'b1;
    tk(4);
    reset = 1'b0;
    global_rst = 1'b0;
    tk(2);
    chk("pin live", pin3_n, 1'b0);
    suspend = 1'b0;
    tk(6);
    chk("ungated", gated, 1'b0);
    rd(`HCR_OFF_SYSTEM_CTRL, 1'b0);
    chk("kept", d, 32'h0700_0002);
    $display("test suspend done");
  endtask
  initial
  begin
    {reset, global_rst, suspend, tx_busy, stop_req, reg_wr, reg_socket} = 7'h60;
    {legacy_busy, master_busy, posted_data, act, wk, fails, checked} = 0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    tk(3);
    reset = 1'b0;
    global_rst = 1'b0;
    rd(`HCR_OFF_SYSTEM_CTRL, 1'b0);
    chk("sys rst", d, `HCR_RST_SYSTEM_CTRL);
    rd(`HCR_OFF_MULTIPIN, 1'b0);
    chk("pins rst", d, `HCR_RST_MULTIPIN);
    chk("pins idle", {pin3_n, pin6_n}, 2'b11);
    rd(12'h044, 1'b0);
    chk("unmapped", d, 32'h0);
    t_smi;
    t_irq2;
    t_float;
    t_clk;
    t_susp;
    conclude;
  end
endmodule
`default_nettype wire
